// file: core/ttu_top.sv
// Triple timer unit with AHB-Lite register slave and one interrupt output.
// Assumes a single bus clock and a demodulator input already synchronous to it.
`timescale 1ns/1ns
`default_nettype none
module ttu_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic demod_in,
	output logic timer_a_out,
	output logic timer_b_out,
	output logic prescale_out,
	output logic irq
);
	import ttu_pkg::*;

	logic [4:0] tick_div;
	logic tick;
	logic [MODE_W-1:0] mode [3];
	logic [15:0] lim_a [3];
	logic [15:0] lim_b [3];
	logic [15:0] cnt [3];
	logic [2:0] tout;
	logic [2:0] tmax;
	logic [2:0] ttick;
	logic [1:0] system_config_reg;
	logic [INT_W-1:0] int_stat;
	logic [INT_W-1:0] int_mask;
	logic [INT_W-1:0] int_set;
	logic demod_prev;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic acc;
	logic [31:0] next_rdata;
	logic psave;

	assign psave = system_config_reg[SYSCFG_PSAVE];
	assign acc = hsel && hready && htrans[HTRANS_ACTIVE];

	// ---------------------------------------------------------------
	// Timer clock divider
	// ---------------------------------------------------------------
	// quarter clock, one thirty-second in power save
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_div <= 5'h00;
			tick <= 1'b0;
		end else begin
			tick <= (tick_div == (psave ? TICK_LAST_SLOW : TICK_LAST_FULL));
			if (tick_div >= (psave ? TICK_LAST_SLOW : TICK_LAST_FULL)) begin
				tick_div <= 5'h00;
			end else begin
				tick_div <= tick_div + 5'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// Three timers
	// ---------------------------------------------------------------
	generate
		for (genvar i = 0; i < 3; i++) begin : g_tmr
			if (i < 2) begin : g_src
				assign ttick[i] = mode[i][MODE_PRESCALED] ? tmax[2] : tick;
			end else begin : g_src
				assign ttick[i] = tick;
			end
			ttu_timer u_timer (
				.hclk(hclk),
				.hresetn(hresetn),
				.tick(ttick[i]),
				.enable(mode[i][MODE_EN]),
				.dual((i < 2) ? mode[i][MODE_DUAL] : 1'b0),
				.limit_a(lim_a[i]),
				.limit_b(lim_b[i]),
				.count(cnt[i]),
				.out_level(tout[i]),
				.at_max(tmax[i])
			);
			assign int_set[i] = tmax[i] && mode[i][MODE_INT_EN];
		end
	endgenerate

	assign timer_a_out = tout[0];
	assign timer_b_out = tout[1];
	assign prescale_out = tout[2];

	// ---------------------------------------------------------------
	// Pulse-width demodulation edges
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			demod_prev <= 1'b0;
		end else begin
			demod_prev <= demod_in;
		end
	end

	assign int_set[INT_RISE] = system_config_reg[SYSCFG_DEMOD] && demod_in && !demod_prev;
	assign int_set[INT_FALL] = system_config_reg[SYSCFG_DEMOD] && !demod_in && demod_prev;

	// ---------------------------------------------------------------
	// AHB-Lite address phase capture
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= acc && hwrite;
			wr_addr <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	// per-timer mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 3; i++) begin
				mode[i] <= MODE_RESET;
				lim_a[i] <= LIMIT_RESET;
				lim_b[i] <= LIMIT_RESET;
			end
			system_config_reg <= SYSCFG_RESET;
			int_mask <= INT_RESET;
		end else if (wr_pend) begin
			for (int i = 0; i < 3; i++) begin
				if (wr_addr == OFF_TA_MODE + 8'(i) * TIMER_STRIDE) begin
					mode[i] <= hwdata[MODE_W-1:0];
				end
				if (wr_addr == OFF_TA_LIMA + 8'(i) * TIMER_STRIDE) begin
					lim_a[i] <= hwdata[15:0];
				end
				if (i < 2 && wr_addr == OFF_TA_LIMB + 8'(i) * TIMER_STRIDE) begin
					lim_b[i] <= hwdata[15:0];
				end
			end
			if (wr_addr == OFF_SYSCFG) begin
				system_config_reg <= hwdata[1:0];
			end
			if (wr_addr == OFF_INT_MASK) begin
				int_mask <= hwdata[INT_W-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status, write one to clear, set wins
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_stat <= INT_RESET;
		end else begin
			if (wr_pend && wr_addr == OFF_INT_STAT) begin
				int_stat <= (int_stat & ~hwdata[INT_W-1:0]) | int_set;
			end else begin
				int_stat <= int_stat | int_set;
			end
		end
	end

	// Level interrupt from unmasked status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat & int_mask);
		end
	end

	// ---------------------------------------------------------------
	// Read data, sampled in the address phase
	// ---------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (haddr[7:0])
			OFF_TA_MODE: next_rdata = {28'h0, mode[0]};
			OFF_TA_CNT: next_rdata = {16'h0, cnt[0]};
			OFF_TA_LIMA: next_rdata = {16'h0, lim_a[0]};
			OFF_TA_LIMB: next_rdata = {16'h0, lim_b[0]};
			OFF_TB_MODE: next_rdata = {28'h0, mode[1]};
			OFF_TB_CNT: next_rdata = {16'h0, cnt[1]};
			OFF_TB_LIMA: next_rdata = {16'h0, lim_a[1]};
			OFF_TB_LIMB: next_rdata = {16'h0, lim_b[1]};
			OFF_TC_MODE: next_rdata = {28'h0, mode[2]};
			OFF_TC_CNT: next_rdata = {16'h0, cnt[2]};
			OFF_TC_LIM: next_rdata = {16'h0, lim_a[2]};
			OFF_SYSCFG: next_rdata = {30'h0, system_config_reg};
			OFF_INT_STAT: next_rdata = {27'h0, int_stat};
			OFF_INT_MASK: next_rdata = {27'h0, int_mask};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (acc && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_TICK_QUIET: assert property ((tick && !psave) ##1 !psave |-> !tick [*3])
		else $error("timer tick came early at full rate");
	AST_TICK_PERIOD: assert property (
		(tick && !psave) ##1 (!psave && !wr_pend) [*3] |=> tick)
		else $error("timer tick missing after four cycles");
	// Ticks may come sooner only once power save has been dropped
	AST_TICK_SLOW: assert property (
		(tick && psave) |=> (!tick || !$past(psave)) [*8])
		else $error("power-save tick came too early");
	AST_WRAP: assert property (
		(mode[0][MODE_EN] && ttick[0] && !mode[0][MODE_DUAL] && cnt[0] == lim_a[0])
		|=> (cnt[0] == 16'h0000 && tmax[0]))
		else $error("timer A did not wrap at its limit");
	AST_FULL_16: assert property (
		(mode[2][MODE_EN] && ttick[2] && cnt[2] == 16'hffff && lim_a[2] == 16'hffff)
		|=> cnt[2] == 16'h0000)
		else $error("prescale timer did not wrap at full count");
	AST_DUAL_SWITCH: assert property (
		(mode[1][MODE_EN] && mode[1][MODE_DUAL] && ttick[1] && tout[1]
		&& cnt[1] == lim_a[1]) |=> !timer_b_out)
		else $error("timer B output did not drop at limit A");
	AST_FULL_INT: assert property (
		(tmax[0] && mode[0][MODE_INT_EN]) |=> int_stat[0] ##1 irq == int_mask[0])
		else $error("full count did not raise status or interrupt");
	AST_DEMOD_RISE: assert property (
		(system_config_reg[SYSCFG_DEMOD] && $rose(demod_in)) |=> int_stat[INT_RISE])
		else $error("rising demod edge not recorded");
	AST_CNT_READ: assert property (
		(acc && !hwrite && haddr[7:0] == OFF_TB_CNT) |=> hrdata[15:0] == $past(cnt[1]))
		else $error("count read returned wrong value");
	AST_PRESCALED: assert property (
		(mode[0][MODE_PRESCALED] && mode[0][MODE_EN] && !tmax[2] && !wr_pend)
		|=> $stable(cnt[0]))
		else $error("prescaled timer A moved without prescale pulse");
	AST_MODE_OFF: assert property (
		(!mode[2][MODE_EN] && !wr_pend) |=> $stable(cnt[2]))
		else $error("disabled timer kept counting");
	AST_SINGLE: assert property (
		(mode[2][MODE_EN] && ttick[2] && cnt[2] == lim_a[2]) |=> cnt[2] == 16'h0000)
		else $error("prescale timer ignored its single limit");
	AST_DEMOD_FALL: assert property (
		(system_config_reg[SYSCFG_DEMOD] && $fell(demod_in)) |=> int_stat[INT_FALL])
		else $error("falling demod edge not recorded");
	AST_DEMOD_OFF: assert property (
		(!system_config_reg[SYSCFG_DEMOD] && !int_stat[INT_RISE]) |=> !int_stat[INT_RISE])
		else $error("demod edge recorded while disabled");
	AST_IRQ_ON: assert property (((int_stat & int_mask) != 5'h00) |=> irq)
		else $error("unmasked status did not raise interrupt");
	AST_IRQ_OFF: assert property (((int_stat & int_mask) == 5'h00) |=> !irq)
		else $error("interrupt high with no unmasked status");
	AST_CNT_STEP: assert property (
		(mode[2][MODE_EN] && ttick[2] && cnt[2] != lim_a[2])
		|=> cnt[2] == $past(cnt[2]) + 16'h0001)
		else $error("prescale timer did not step by one");
	AST_OUT_A_WRAP: assert property ($changed(timer_a_out) |-> tmax[0])
		else $error("timer A output moved without a wrap");
	AST_OUT_B_WRAP: assert property ($changed(timer_b_out) |-> tmax[1])
		else $error("timer B output moved without a wrap");
	AST_STAT_HOLD: assert property (
		(int_stat[2] && !(wr_pend && wr_addr == OFF_INT_STAT && hwdata[2])) |=> int_stat[2])
		else $error("timer C status lost without a clear");

	COV_WRAP_A: cover property (tmax[0] ##[1:40] tmax[0]);
	COV_DUAL_B: cover property (mode[1][MODE_DUAL] && $fell(timer_b_out));
	COV_DEMOD: cover property (int_stat[INT_RISE] && int_stat[INT_FALL]);
	COV_IRQ: cover property ($rose(irq));
	COV_PRESCALE_A: cover property (mode[0][MODE_PRESCALED] && tmax[0]);

endmodule
`default_nettype wire

// file: core/ttu_pkg.sv
// Constants shared by the triple timer unit: offsets, fields, resets, divides.
// Assumes a 25 MHz bus clock feeding both the bus slave and the timers.
package ttu_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int TIMER_DIV = 4;
	localparam int POWER_SAVE_DIV = 8;
	localparam logic [4:0] TICK_LAST_FULL = 5'(TIMER_DIV - 1);
	localparam logic [4:0] TICK_LAST_SLOW = 5'(TIMER_DIV * POWER_SAVE_DIV - 1);

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_TA_MODE = 8'h00;
	localparam logic [7:0] OFF_TA_CNT = 8'h04;
	localparam logic [7:0] OFF_TA_LIMA = 8'h08;
	localparam logic [7:0] OFF_TA_LIMB = 8'h0c;
	localparam logic [7:0] OFF_TB_MODE = 8'h10;
	localparam logic [7:0] OFF_TB_CNT = 8'h14;
	localparam logic [7:0] OFF_TB_LIMA = 8'h18;
	localparam logic [7:0] OFF_TB_LIMB = 8'h1c;
	localparam logic [7:0] OFF_TC_MODE = 8'h20;
	localparam logic [7:0] OFF_TC_CNT = 8'h24;
	localparam logic [7:0] OFF_TC_LIM = 8'h28;
	localparam logic [7:0] OFF_SYSCFG = 8'h2c;
	localparam logic [7:0] OFF_INT_STAT = 8'h30;
	localparam logic [7:0] OFF_INT_MASK = 8'h34;
	localparam logic [7:0] TIMER_STRIDE = 8'h10;

	// ---------------------------------------------------------------
	// Mode register fields
	// ---------------------------------------------------------------
	localparam int MODE_W = 4;
	localparam int MODE_EN = 0;
	localparam int MODE_INT_EN = 1;
	localparam int MODE_DUAL = 2;
	localparam int MODE_PRESCALED = 3;
	localparam logic [3:0] MODE_RESET = 4'h0;

	// ---------------------------------------------------------------
	// System configuration and interrupt fields
	// ---------------------------------------------------------------
	localparam int SYSCFG_DEMOD = 0;
	localparam int SYSCFG_PSAVE = 1;
	localparam logic [1:0] SYSCFG_RESET = 2'h0;
	localparam int INT_W = 5;
	localparam int INT_RISE = 3;
	localparam int INT_FALL = 4;
	localparam logic [4:0] INT_RESET = 5'h00;
	localparam logic [15:0] LIMIT_RESET = 16'hffff;

	// AHB transfer type bit that marks NONSEQ or SEQ
	localparam int HTRANS_ACTIVE = 1;

endpackage

// file: core/ttu_timer.sv
// One sixteen-bit up counter with one or two limits and a level output.
// Assumes a one-cycle count enable pulse from the surrounding unit.
`timescale 1ns/1ns
`default_nettype none
module ttu_timer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tick,
	input wire logic enable,
	input wire logic dual,
	input wire logic [15:0] limit_a,
	input wire logic [15:0] limit_b,
	output logic [15:0] count,
	output logic out_level,
	output logic at_max
);
	import ttu_pkg::*;

	logic [15:0] active_limit;

	// Limit B applies while the output is low in dual mode
	assign active_limit = (dual && !out_level) ? limit_b : limit_a;

	// ---------------------------------------------------------------
	// Counter, output level and full-count pulse
	// ---------------------------------------------------------------
	// wrap to zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 16'h0000;
			out_level <= 1'b1;
			at_max <= 1'b0;
		end else begin
			at_max <= 1'b0;
			if (enable && tick) begin
				if (count == active_limit) begin
					count <= 16'h0000;
					at_max <= 1'b1;
					out_level <= !out_level; // Toggle output, which selects the other limit in dual mode
				end else begin
					count <= count + 16'h0001;
				end
			end
		end
	end

endmodule
`default_nettype wire

// file: tb/ttu_top_tb.sv
// Self-checking bench for the triple timer unit over its AHB-Lite slave.
// Assumes a single slave, so hready follows the design's hreadyout.
`timescale 1ns/1ns
`default_nettype none
module ttu_top_tb;
import ttu_pkg::*;
// ---------------------------------------------------------------
// Signals
// ---------------------------------------------------------------
logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, demod_in = 0;
logic [31:0] haddr = 0, hwdata = 0, hrdata;
logic [1:0] htrans = 0;
logic [2:0] hsize = 3'b010;
wire hready;
logic hreadyout, hresp, irq, ta_out, tb_out, tc_out, rd_pend = 0;
logic [63:0] exp_q[$];
logic [63:0] note;
logic [7:0] lim_off [5] = '{OFF_TA_LIMA, OFF_TA_LIMB, OFF_TB_LIMA, OFF_TB_LIMB, OFF_TC_LIM};
logic [7:0] cnt_off [3] = '{OFF_TA_CNT, OFF_TB_CNT, OFF_TC_CNT};
int checks = 0, fail_count = 0, cyc = 0;
always #20 hclk = ~hclk;
assign hready = hreadyout;
ttu_top i_ttu_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .demod_in(demod_in),
	.timer_a_out(ta_out), .timer_b_out(tb_out), .prescale_out(tc_out), .irq(irq));
// ---------------------------------------------------------------
// Checking and closing
// ---------------------------------------------------------------
task chk(input logic ok, input string msg);
	checks++;
	if (ok !== 1'b1) begin
		fail_count++;
		$display("CHECK FAILED at %0t: %s", $time, msg);
	end
endtask
task close_out();
	$display("checks %0d, mismatches %0d", checks, fail_count);
	if (fail_count == 0 && checks > 0) begin
		$display("Regression OK");
	end else begin
		$display("Regression broken");
	end
	$finish;
endtask
// Read monitor: compares data phase against oldest note
always @(posedge hclk) begin
	if (rd_pend) begin
		note = exp_q.pop_front();
		chk((((hrdata ^ note[31:0]) & note[63:32]) === 32'h0) && hresp === 1'b0, "read data");
	end
	rd_pend <= hsel & hready & htrans[1] & ~hwrite;
end
// Hang guard
always @(posedge hclk) begin
	cyc++;
	if (cyc == 20000) begin
		fail_count++;
		$display("CHECK FAILED at %0t: timeout", $time);
		close_out();
	end
end
// ---------------------------------------------------------------
// Bus and measurement tasks
// ---------------------------------------------------------------
task addr_ph(input logic [7:0] a, input logic w);
	hsel <= 1'b1;
	haddr <= {24'h0, a};
	htrans <= 2'b10;
	hwrite <= w;
	do @(posedge hclk); while (hready !== 1'b1);
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
	addr_ph(a, 1'b1);
	htrans <= 2'b00;
	hsel <= 1'b0;
	hwdata <= d;
	do @(posedge hclk); while (hready !== 1'b1);
endtask
task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
	exp_q.push_back({m, e});
	addr_ph(a, 1'b0);
	htrans <= 2'b00;
	hsel <= 1'b0;
	do @(posedge hclk); while (hready !== 1'b1);
endtask
function logic pick(input int s);
	return (s == 0) ? ta_out : (s == 1) ? tb_out : tc_out;
endfunction
// Length in clocks of one full stretch at level lvl
task meas(input int s, input logic lvl, input int e, input string msg);
	int n;
	n = 0;
	while (pick(s) !== ~lvl) @(posedge hclk);
	while (pick(s) !== lvl) @(posedge hclk);
	while (pick(s) === lvl) begin
		@(posedge hclk);
		n++;
	end
	chk(n == e, msg);
endtask
// ---------------------------------------------------------------
// Main sequence
// ---------------------------------------------------------------
initial begin
	int i;
	logic [31:0] r;
	void'($urandom(32'hf6b6));
	repeat (4) @(posedge hclk);
	hresetn <= 1'b1;
	@(posedge hclk);
	chk(ta_out === 1'b1 && tb_out === 1'b1 && tc_out === 1'b1 && irq === 1'b0, "reset pins");
	for (i = 0; i < 15; i++) begin
		rd(8'(i * 4), (i inside {2, 3, 6, 7, 10}) ? 32'hffff : 32'h0, 32'hffffffff);
	end
	$display("test reset values done");
	foreach (lim_off[k]) begin
		r = $urandom;
		wr(lim_off[k], r);
		rd(lim_off[k], {16'h0, r[15:0]}, 32'hffffffff);
	end
	foreach (cnt_off[k]) begin
		wr(cnt_off[k], $urandom);
		rd(cnt_off[k], 32'h0, 32'hffffffff);
	end
	$display("test limits and counts done");
	wr(OFF_TA_LIMA, 32'h3);
	wr(OFF_INT_MASK, 32'h1);
	wr(OFF_TA_MODE, 32'h3);
	fork
		meas(0, 1'b1, 16, "timer a period");
		repeat (6) rd(OFF_TA_CNT, 32'h0, 32'hfffffffc);
	join
	chk(irq === 1'b1, "full count irq");
	rd(OFF_INT_STAT, 32'h1, 32'h1);
	wr(OFF_TA_MODE, 32'h1);
	wr(OFF_INT_STAT, 32'h1);
	repeat (3) @(posedge hclk);
	chk(irq === 1'b0, "irq cleared");
	repeat (40) @(posedge hclk);
	rd(OFF_INT_STAT, 32'h0, 32'h1);
	$display("test timer a done");
	wr(OFF_SYSCFG, 32'h2);
	meas(0, 1'b0, 128, "power save period");
	wr(OFF_SYSCFG, 32'h0);
	$display("test power save done");
	wr(OFF_TB_LIMA, 32'h2);
	wr(OFF_TB_LIMB, 32'h5);
	wr(OFF_TB_MODE, 32'h7);
	meas(1, 1'b1, 12, "dual high");
	meas(1, 1'b0, 24, "dual low");
	rd(OFF_TB_CNT, 32'h0, 32'hfffffff8);
	rd(OFF_INT_STAT, 32'h2, 32'h2);
	$display("test dual limit done");
	wr(OFF_TC_LIM, 32'h1);
	wr(OFF_TC_MODE, 32'h7);
	meas(2, 1'b1, 8, "single limit c");
	rd(OFF_INT_STAT, 32'h4, 32'h4);
	// Limit kept at 3: a lower limit below the running count would run to ffff
	wr(OFF_TA_LIMA, 32'h3);
	wr(OFF_TA_MODE, 32'h9);
	@(posedge hclk);
	meas(0, 1'b1, 32, "prescaled a");
	$display("test prescale done");
	wr(OFF_INT_MASK, 32'h0);
	wr(OFF_SYSCFG, 32'h1);
	demod_in <= 1'b1;
	repeat (4) @(posedge hclk);
	chk(irq === 1'b0, "masked demod");
	rd(OFF_INT_STAT, 32'h8, 32'h18);
	wr(OFF_INT_MASK, 32'h18);
	repeat (3) @(posedge hclk);
	chk(irq === 1'b1, "demod irq");
	wr(OFF_INT_STAT, 32'h8);
	repeat (3) @(posedge hclk);
	chk(irq === 1'b0, "demod clear");
	demod_in <= 1'b0;
	repeat (4) @(posedge hclk);
	rd(OFF_INT_STAT, 32'h10, 32'h18);
	wr(OFF_INT_STAT, 32'h1f);
	wr(OFF_SYSCFG, 32'h0);
	demod_in <= 1'b1;
	repeat (4) @(posedge hclk);
	rd(OFF_INT_STAT, 32'h0, 32'h18);
	$display("test demodulation done");
	repeat (3) @(posedge hclk);
	close_out();
end
endmodule
`default_nettype wire
